// *** arrs_pkg.sv ***
// Constants and types for the converter result readout sequencer
package arrs_pkg;

	// ------------------------------------------------
	// Sizes and timing
	// ------------------------------------------------
	localparam int NCH          = 4;
	localparam int DW           = 14;
	localparam int CLK_PERIOD_NS = 4;
	localparam int INT_STEP_NS  = 150;
	localparam int INT_STEP_CYC = (INT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXT_GUARD_NS = 200;
	localparam int EXT_GUARD_CYC = (EXT_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Clock edge numbers within one channel conversion
	localparam logic [4:0] EDGE_PTR = 5'h0e;
	localparam logic [4:0] EDGE_EOC = 5'h0f;
	localparam logic [4:0] EDGE_END = 5'h10;

	// ------------------------------------------------
	// Register map
	// ------------------------------------------------
	localparam logic [7:0] REG_CHAN = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [3:0] CHAN_RST = 4'hf;
	localparam int STAT_BUSY    = 0;
	localparam int STAT_FRST    = 1;
	localparam int STAT_STANDBY_N    = 2;
	localparam int STAT_PEND    = 3;
	localparam int STAT_PTR_LSB = 4;
	localparam int STAT_CNT_LSB = 8;

	// ------------------------------------------------
	// Carriers
	// ------------------------------------------------
	typedef struct packed {
		logic       conversion_start_n;
		logic       cs_n;
		logic       rd_n;
		logic       conv_clock_in;
		logic       clock_source_sel;
		logic       hw_sw_sel;
		logic       standby_n;
		logic [3:0] chan_pins;
	} arrs_pins_t;

	localparam arrs_pins_t PINS_IDLE = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 4'h0};

	typedef struct packed {
		logic          busy;
		logic          eoc_n;
		logic          first_result_flag;
		logic          result_oe;
		logic [DW-1:0] result_bus;
	} arrs_out_t;

	typedef enum {ST_IDLE, ST_CONV, ST_TAIL} arrs_state_t;

endpackage : arrs_pkg

// *** arrs_sequencer.sv ***
// Result bank, read pointer and conversion timing of a four-channel sampling converter
// How it works
// - Results stored in registers by sequence order.
// - Fourteenth edge of first conversion resets pointer to one.
// - Flag rises when pointer reset to one.
// - Chip-select and read low drive addressed result.
// - After sequence, read rising edge advances pointer.
// - Early read holds pointer until result lands.
// - Reading last result wraps pointer to one.
// - Flag drops after first read after sequence.
// - Flag level at power-up is undefined; reset clears it here.
// - Successive reads return results in ascending order.
// - Both selects high use external conversion clock.
// - Busy rises with start; clock edges wait.
// - Fourteenth falling edge resets pointer, raises flag.
// - Fifteenth edge ends conversion; sixteenth releases.
// - Each further channel takes sixteen clock pulses.
// - Last conversion drops busy and end together.
// - Standby input low enters standby state.
// - Results stay readable during standby.
// - Start rising edge holds inputs, begins sequence.
// - Channels converted in ascending channel order.
`timescale 1ns/1ps
`default_nettype none

module arrs_sequencer
	import arrs_pkg::*;
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  sys_rst,
	// APB slave
	input  wire logic [7:0]            paddr,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           pwdata,
	output var  logic [31:0]           prdata,
	output var  logic                  pready,
	output var  logic                  pslverr,
	// Device pins and converter data
	input  wire arrs_pins_t            pins,
	input  wire logic [NCH-1:0][DW-1:0] sample_data,
	output wire arrs_out_t             pins_out,
	output var  logic                  standby_active
);

	// ------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------
	localparam int PW = $bits(arrs_pins_t);
	logic [PW-1:0] s1_r, s2_r, s3_r, filt_r, filt_d_r;
	arrs_pins_t    f, fd;

	genvar gi;
	generate
		for (gi = 0; gi < PW; gi++) begin : g_sync
			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					s1_r[gi]   <= PINS_IDLE[gi];
					s2_r[gi]   <= PINS_IDLE[gi];
					s3_r[gi]   <= PINS_IDLE[gi];
					filt_r[gi] <= PINS_IDLE[gi];
				end else begin
					s1_r[gi] <= pins[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
					if (s2_r[gi] == s3_r[gi]) begin
						filt_r[gi] <= s3_r[gi];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			filt_d_r <= PINS_IDLE;
		end else begin
			filt_d_r <= filt_r;
		end
	end

	assign f  = arrs_pins_t'(filt_r);
	assign fd = arrs_pins_t'(filt_d_r);

	logic start_rise, rd_rise, clk_fall, ext_sel;
	assign start_rise = f.conversion_start_n & ~fd.conversion_start_n;
	assign rd_rise    = f.rd_n & ~fd.rd_n & ~f.cs_n;
	assign clk_fall   = ~f.conv_clock_in & fd.conv_clock_in;
	assign ext_sel    = f.hw_sw_sel & f.clock_source_sel;

	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	function automatic logic [1:0] lowest(input logic [NCH-1:0] m);
		logic [1:0] r;
		r = 2'h0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (m[i]) begin
				r = 2'(i);
			end
		end
		return r;
	endfunction : lowest

	function automatic logic [2:0] popcnt(input logic [NCH-1:0] m);
		logic [2:0] c;
		c = 3'h0;
		for (int i = 0; i < NCH; i++) begin
			c = c + 3'(m[i]);
		end
		return c;
	endfunction : popcnt

	// ------------------------------------------------
	// Registers and status
	// ------------------------------------------------
	logic [3:0]  chan_reg_r;
	logic        busy_r, eoc_n_r, frst_r, pend_r, oe_r;
	logic [1:0]  ptr_r;
	logic [2:0]  avail_r;
	logic [31:0] stat_w;

	always_comb begin
		stat_w = 32'h0;
		stat_w[STAT_BUSY] = busy_r;
		stat_w[STAT_FRST] = frst_r;
		stat_w[STAT_STANDBY_N] = standby_active;
		stat_w[STAT_PEND] = pend_r;
		stat_w[STAT_PTR_LSB +: 2] = ptr_r;
		stat_w[STAT_CNT_LSB +: 3] = avail_r;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pready     <= 1'h0;
			pslverr    <= 1'h0;
			prdata     <= 32'h0;
			chan_reg_r <= CHAN_RST;
		end else begin
			pready  <= 1'h0;
			pslverr <= 1'h0;
			prdata  <= 32'h0;
			if (psel && penable && !pready) begin
				pready <= 1'h1;
				unique case (paddr)
					REG_CHAN: begin
						if (pwrite) begin
							chan_reg_r <= pwdata[3:0];
						end else begin
							prdata <= {28'h0, chan_reg_r};
						end
					end
					REG_STAT: begin
						if (!pwrite) begin
							prdata <= stat_w;
						end
					end
					default: begin
						pslverr <= 1'h1;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------
	// Standby
	// ------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			standby_active <= 1'h0;
		end else begin
			standby_active <= ~f.standby_n;
		end
	end

	// ------------------------------------------------
	// Conversion timing
	// ------------------------------------------------
	arrs_state_t state_r;
	logic [4:0]  phase_r, ph_nxt;
	logic [NCH-1:0] mask_r, sel_mask, rest_mask;
	logic [1:0]  cur_r;
	logic [2:0]  wr_idx_r, total_r;
	logic        first_r, mode_ext_r, start_acc, step, load, first_tick, last_conv;
	logic [$clog2(INT_STEP_CYC)-1:0] div_r;
	logic [$clog2(EXT_GUARD_CYC+1)-1:0] guard_r;

	assign sel_mask   = f.hw_sw_sel ? chan_reg_r : f.chan_pins;
	assign start_acc  = (state_r == ST_IDLE) && start_rise && f.standby_n && (sel_mask != 4'h0);
	assign ph_nxt     = phase_r + 5'h01;
	assign rest_mask  = mask_r & ~(4'h1 << cur_r);
	assign last_conv  = (wr_idx_r == total_r - 3'h1);
	assign load       = step && (ph_nxt == EDGE_EOC);
	assign first_tick = step && (ph_nxt == EDGE_PTR) && first_r;

	always_comb begin
		step = 1'h0;
		if (state_r != ST_IDLE) begin
			if (mode_ext_r) begin
				step = clk_fall && (guard_r == ($bits(guard_r))'(EXT_GUARD_CYC));
			end else begin
				step = (div_r == ($bits(div_r))'(INT_STEP_CYC - 1));
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst || state_r == ST_IDLE) begin
			div_r   <= '0;
			guard_r <= '0;
		end else begin
			div_r <= (div_r == ($bits(div_r))'(INT_STEP_CYC - 1)) ? '0 : div_r + 1'h1;
			if (guard_r != ($bits(guard_r))'(EXT_GUARD_CYC)) begin
				guard_r <= guard_r + 1'h1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_r    <= ST_IDLE;
			busy_r     <= 1'h0;
			eoc_n_r    <= 1'h1;
			phase_r    <= 5'h00;
			mask_r     <= 4'h0;
			cur_r      <= 2'h0;
			wr_idx_r   <= 3'h0;
			total_r    <= 3'h0;
			first_r    <= 1'h0;
			mode_ext_r <= 1'h0;
		end else if (start_acc) begin
			state_r    <= ST_CONV;
			busy_r     <= 1'h1;
			mode_ext_r <= ext_sel;
			mask_r     <= sel_mask;
			cur_r      <= lowest(sel_mask);
			total_r    <= popcnt(sel_mask);
			wr_idx_r   <= 3'h0;
			phase_r    <= 5'h00;
			first_r    <= 1'h1;
		end else if (step) begin
			phase_r <= ph_nxt;
			if (ph_nxt == EDGE_EOC) begin
				eoc_n_r <= 1'h0;
				if (last_conv) begin
					busy_r  <= 1'h0;
					state_r <= ST_TAIL;
				end
			end
			if (ph_nxt == EDGE_END) begin
				eoc_n_r  <= 1'h1;
				phase_r  <= 5'h00;
				first_r  <= 1'h0;
				wr_idx_r <= wr_idx_r + 3'h1;
				mask_r   <= rest_mask;
				cur_r    <= lowest(rest_mask);
				if (state_r == ST_TAIL) begin
					state_r <= ST_IDLE;
				end
			end
		end
	end

	// ------------------------------------------------
	// Result bank
	// ------------------------------------------------
	logic [DW-1:0] res_r [NCH];

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			res_r <= '{default: '0};
		end else if (load) begin
			res_r[wr_idx_r[1:0]] <= sample_data[cur_r];
		end
	end

	// ------------------------------------------------
	// Read pointer and first-result flag
	// ------------------------------------------------
	logic [2:0] ptr_inc;
	logic       rd_only;
	assign ptr_inc = {1'h0, ptr_r} + 3'h1;
	assign rd_only = rd_rise && !load && !first_tick;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ptr_r   <= 2'h0;
			avail_r <= 3'h0;
			pend_r  <= 1'h0;
			frst_r  <= 1'h0;
		end else if (first_tick) begin
			ptr_r   <= 2'h0;
			avail_r <= 3'h0;
			pend_r  <= 1'h0;
			frst_r  <= 1'h1;
		end else if (load) begin
			avail_r <= wr_idx_r + 3'h1;
			if (pend_r) begin
				ptr_r  <= ptr_r + 2'h1;
				pend_r <= 1'h0;
				frst_r <= 1'h0;
			end
		end else if (rd_rise && avail_r != 3'h0) begin
			if (!busy_r) begin
				if (ptr_inc == avail_r) begin
					ptr_r  <= 2'h0;
					frst_r <= 1'h1;
				end else begin
					ptr_r  <= ptr_r + 2'h1;
					frst_r <= 1'h0;
				end
			end else if (ptr_inc < avail_r) begin
				ptr_r  <= ptr_r + 2'h1;
				frst_r <= 1'h0;
			end else begin
				pend_r <= 1'h1;
			end
		end
	end

	// ------------------------------------------------
	// Output drivers
	// ------------------------------------------------
	logic [DW-1:0] bus_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			oe_r  <= 1'h0;
			bus_r <= '0;
		end else begin
			oe_r  <= ~f.cs_n & ~f.rd_n;
			bus_r <= res_r[ptr_r];
		end
	end

	assign pins_out = '{busy_r, eoc_n_r, frst_r, oe_r, bus_r};

	// ------------------------------------------------
	// Checks
	// ------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_first_tick;
		first_tick;
	endsequence
	sequence s_last_load;
		load && last_conv;
	endsequence
	sequence s_done_read;
		rd_only && !busy_r && avail_r != 3'h0;
	endsequence

	chk_busy_on_start: assert property (start_acc |=> busy_r && eoc_n_r)
		else $error("busy not raised at start");
	chk_ptr_first_rst: assert property (s_first_tick |=> ptr_r == 2'h0 && frst_r)
		else $error("pointer not reset on first edge");
	chk_eoc_pulse: assert property (load |=> !eoc_n_r ##1 (!eoc_n_r) [*1] ##0 !load)
		else $error("end strobe missing on load");
	chk_busy_last: assert property (s_last_load |=> !busy_r && !eoc_n_r)
		else $error("busy not dropped on last result");
	chk_read_drive: assert property (!f.cs_n && !f.rd_n |=> oe_r ##1 bus_r == $past(res_r[ptr_r]))
		else $error("read data not driven");
	chk_ptr_wrap: assert property ((s_done_read and (ptr_inc == avail_r)) |=> ptr_r == 2'h0 && frst_r)
		else $error("pointer did not wrap");
	chk_flag_drop: assert property ((s_done_read and (ptr_r == 2'h0 && avail_r > 3'h1)) |=> !frst_r && ptr_r == 2'h1)
		else $error("first flag did not drop");
	chk_pend_hold: assert property (rd_only && busy_r && avail_r != 3'h0 && ptr_inc >= avail_r
		|=> pend_r && ptr_r == $past(ptr_r))
		else $error("early read moved pointer");
	chk_ext_clock: assert property (start_acc && ext_sel |=> mode_ext_r)
		else $error("external clock not selected");
	chk_ascending: assert property (step && ph_nxt == EDGE_END && rest_mask != 4'h0 |=> cur_r > $past(cur_r))
		else $error("channel order not ascending");

endmodule : arrs_sequencer

`default_nettype wire

// *** arrs_host_model.sv ***
// Host-side conversion clock source for the readout sequencer bench
`timescale 1ns/1ps
`default_nettype none

module arrs_host_model (
	// Clock
	input  wire logic       sys_clk,
	// Control
	input  wire logic       run,
	// Conversion clock and its count of falling edges
	output var  logic       clk_out,
	output var  logic [7:0] falls
);
	int cnt;

	// ------------------------------------------------
	// Clock stands high outside a frame, 5 MHz inside
	// ------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!run) begin
			clk_out <= 1'h1;
			cnt     <= 0;
			falls   <= 8'h00;
		end else begin
			cnt <= (cnt == 49) ? 0 : cnt + 1;
			if (cnt == 24)
				clk_out <= 1'h1;
			if (cnt == 49) begin
				clk_out <= 1'h0;
				falls   <= falls + 8'h01;
			end
		end
	end
endmodule : arrs_host_model
`default_nettype wire

// *** arrs_sequencer_test.sv ***
// Self-checking bench for the converter result readout sequencer
`timescale 1ns/1ps
`default_nettype none

module arrs_sequencer_test
	import arrs_pkg::*;
;
	logic                   sys_clk = 1'h0;
	logic                   sys_rst = 1'h1;
	logic [7:0]             paddr   = 8'h00;
	logic                   psel    = 1'h0;
	logic                   penable = 1'h0;
	logic                   pwrite  = 1'h0;
	logic [31:0]            pwdata  = 32'h0;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	logic                   standby_active;
	logic                   run     = 1'h0;
	logic                   ext_clk;
	logic [7:0]             falls;
	arrs_pins_t             pins_tb = PINS_IDLE;
	arrs_pins_t             pins_w;
	arrs_out_t              pins_out;
	logic [NCH-1:0][DW-1:0] sd      = {14'h3c04, 14'h2b03, 14'h1a02, 14'h0901};
	logic [31:0]            rd;
	logic                   err;
	int                     fails    = 0;
	int                     compares = 0;
	int                     cyc      = 0;
	int                     n;

	// ------------------------------------------------
	// Clock, pins and instances
	// ------------------------------------------------
	always #2 sys_clk = ~sys_clk;

	always_comb begin
		pins_w = pins_tb;
		pins_w.conv_clock_in = ext_clk;
	end

	arrs_sequencer i_arrs_sequencer (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pins(pins_w), .sample_data(sd), .pins_out(pins_out), .standby_active(standby_active)
	);

	arrs_host_model i_arrs_host_model (
		.sys_clk(sys_clk), .run(run), .clk_out(ext_clk), .falls(falls)
	);

	// ------------------------------------------------
	// Tasks
	// ------------------------------------------------
	task automatic close_out();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fails++;
			close_out();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel    <= 1'h1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		do @(posedge sys_clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic rd_strobe(input logic [DW-1:0] exp, input logic fl);
		@(posedge sys_clk);
		pins_tb.cs_n <= 1'h0;
		pins_tb.rd_n <= 1'h0;
		repeat (8) @(posedge sys_clk);
		check(32'(pins_out.result_oe), 32'h1, "drive on");
		check(32'(pins_out.result_bus), 32'(exp), "data");
		pins_tb.rd_n <= 1'h1;
		repeat (8) @(posedge sys_clk);
		pins_tb.cs_n <= 1'h1;
		repeat (8) @(posedge sys_clk);
		check(32'(pins_out.result_oe), 32'h0, "drive off");
		check(32'(pins_out.first_result_flag), 32'(fl), "flag");
	endtask : rd_strobe

	task automatic convert(input int nexp, input logic ext);
		int   e;
		logic pe;
		logic pf;
		e = 0;
		pe = 1'h1;
		pf = pins_out.first_result_flag;
		@(posedge sys_clk);
		pins_tb.conversion_start_n <= 1'h0;
		repeat (6) @(posedge sys_clk);
		pins_tb.conversion_start_n <= 1'h1;
		repeat (12) @(posedge sys_clk);
		check(32'(pins_out.busy), 32'h1, "busy rise");
		repeat (28) @(posedge sys_clk);
		run <= ext;
		while (pins_out.busy === 1'h1) begin
			@(posedge sys_clk);
			if (ext && !pf && pins_out.first_result_flag === 1'h1)
				check(32'(falls), 32'h0e, "flag edge");
			if (ext && pe && pins_out.eoc_n === 1'h0)
				check(32'(falls), 15 + 16 * e, "eoc edge");
			if (pe && pins_out.eoc_n === 1'h0)
				e++;
			pe = pins_out.eoc_n;
			pf = pins_out.first_result_flag;
		end
		check(32'(pins_out.eoc_n), 32'h0, "eoc with busy");
		check(e, nexp, "eoc count");
		n = 0;
		while (pins_out.eoc_n !== 1'h1 && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
		if (ext)
			check(32'(falls), 16 * nexp, "eoc release");
		run <= 1'h0;
	endtask : convert

	// ------------------------------------------------
	// Tests
	// ------------------------------------------------
	initial begin
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'h0;
		repeat (2) @(posedge sys_clk);
		check(32'(pins_out), 32'h00010000, "reset outputs");
		apb(1'h0, REG_CHAN, 32'h0);
		check(rd, 32'(CHAN_RST), "chan reset");
		apb(1'h1, REG_CHAN, 32'h0000000a);
		apb(1'h0, REG_CHAN, 32'h0);
		check(rd, 32'h0000000a, "chan write");
		apb(1'h1, REG_STAT, 32'h000000ff);
		apb(1'h0, REG_STAT, 32'h0);
		check(32'(rd[2:0]), 32'h0, "status ro");
		apb(1'h0, 8'h08, 32'h0);
		check(32'(err), 32'h1, "unmapped");
		$display("test registers done");
		pins_tb.chan_pins <= 4'hd;
		convert(3, 1'h0);
		check(32'(pins_out.first_result_flag), 32'h1, "flag set");
		rd_strobe(sd[0], 1'h0);
		rd_strobe(sd[2], 1'h0);
		rd_strobe(sd[3], 1'h1);
		rd_strobe(sd[0], 1'h0);
		$display("test internal clock done");
		pins_tb.hw_sw_sel <= 1'h1;
		pins_tb.clock_source_sel <= 1'h1;
		fork
			convert(2, 1'h1);
			begin
				wait (falls == 8'h14);
				rd_strobe(sd[1], 1'h1);
			end
		join
		check(32'(pins_out.first_result_flag), 32'h0, "pending moved");
		rd_strobe(sd[3], 1'h1);
		$display("test external clock done");
		pins_tb.standby_n <= 1'h0;
		repeat (10) @(posedge sys_clk);
		check(32'(standby_active), 32'h1, "standby on");
		pins_tb.conversion_start_n <= 1'h0;
		repeat (6) @(posedge sys_clk);
		pins_tb.conversion_start_n <= 1'h1;
		repeat (12) @(posedge sys_clk);
		check(32'(pins_out.busy), 32'h0, "start in standby");
		rd_strobe(sd[1], 1'h0);
		pins_tb.standby_n <= 1'h1;
		repeat (10) @(posedge sys_clk);
		check(32'(standby_active), 32'h0, "standby off");
		repeat (250) @(posedge sys_clk);
		convert(2, 1'h1);
		rd_strobe(sd[1], 1'h0);
		$display("test standby done");
		close_out();
	end
endmodule : arrs_sequencer_test
`default_nettype wire
